/* File: pkg/lpwc_pkg.sv */
// Package: constants, source indices and carrier types for the low-power wake control
package lpwc_pkg;

    // Interrupt source indices in the request vector
    localparam int SRC_SERIAL = 0;
    localparam int SRC_CSIO_I2C = 1;
    localparam int SRC_KEY = 2;
    localparam int SRC_ADC = 3;
    localparam int SRC_PET = 4;
    localparam int SRC_GTB = 5;
    localparam int SRC_CAL = 6;
    localparam int SRC_EXT0 = 7;
    localparam int SRC_EXT1 = 8;
    localparam int SRC_EXT3 = 9;
    localparam int SRC_VMON1 = 10;
    localparam int SRC_VMON2 = 11;
    localparam int SRC_OSCSTOP = 12;
    localparam int NUM_SRC = 13;

    // Pulse event timer count source encodings
    localparam logic [1:0] PET_SRC_DIV = 2'h0;
    localparam logic [1:0] PET_SRC_OCO = 2'h1;
    localparam logic [1:0] PET_SRC_SUB32 = 2'h2;
    localparam logic [1:0] PET_SRC_EXT = 2'h3;

    // Wake latency figures
    localparam int FLASH_SYS_CYCLES = 12;
    localparam int FLASH_WAKE_NS = 30000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int FLASH_WAKE_CYCLES = FLASH_WAKE_NS / CLK_PERIOD_NS;
    localparam int CPU_RESTART_CYCLES = 6;
    localparam int IRQ_SEQ_CYCLES = 20;
    localparam int CNT_W = 16;

    // Peripheral setup that decides which requests may wake the device
    typedef struct packed {
        logic serial_ext_clk;   // Serial interface on external clock
        logic adc_single;       // Converter in single-conversion mode
        logic pet_event_mode;   // Pulse event timer in event-counter mode
        logic pet_filter_on;    // Pulse event timer input filter on
        logic [1:0] pet_src;    // Pulse event timer count source
        logic cal_rtc_mode;     // Calendar timer in real-time-clock mode
        logic ext0_filter_on;
        logic ext1_filter_on;
        logic ext3_filter_on;
        logic vmon1_filter_off;
        logic vmon2_filter_off;
    } lpwc_periph_cfg_t;

    // Power state, one-hot
    typedef enum logic [5:0] {
        PS_RUN   = 6'h01,
        PS_SLEEP = 6'h02,
        PS_STOP  = 6'h04,
        PS_FLASH = 6'h08,
        PS_CLKRS = 6'h10,
        PS_IRQSQ = 6'h20
    } lpwc_state_t;

    // Clock gating outputs
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;    // f1, f2, f4, f8, f32
        logic osc_en;
        logic flash_en;
    } lpwc_clk_ctl_t;

endpackage

/* File: logic/lpwc_wake_filter.sv */
// Wake qualification: which pending requests may end sleep or stop
`timescale 1ns/1ps
module lpwc_wake_filter
    import lpwc_pkg::*;
(
    input wire logic [NUM_SRC-1:0] irq_req,       // Pending peripheral requests
    input wire logic [NUM_SRC-1:0] irq_enabled,   // Priority level nonzero
    input wire lpwc_periph_cfg_t cfg,             // Peripheral setup
    input wire logic periph_halt,                 // Peripheral clocks halt in sleep
    output logic sleep_wake,                      // Request may end sleep
    output logic stop_wake                        // Request may end stop
);
    logic [NUM_SRC-1:0] ok_run;
    logic [NUM_SRC-1:0] ok_halt;
    logic [NUM_SRC-1:0] ok_stop;
    logic [NUM_SRC-1:0] live;
    wire pet_no_filt_evt = cfg.pet_event_mode & ~cfg.pet_filter_on;
    wire pet_osc_src = (cfg.pet_src == PET_SRC_OCO) | (cfg.pet_src == PET_SRC_SUB32);

    always_comb begin
        ok_run = '1;
        ok_run[SRC_ADC] = cfg.adc_single;
        ok_halt = '0;
        ok_halt[SRC_SERIAL] = cfg.serial_ext_clk;
        ok_halt[SRC_KEY] = 1'b1;
        ok_halt[SRC_PET] = pet_no_filt_evt | pet_osc_src;
        ok_halt[SRC_CAL] = cfg.cal_rtc_mode;
        ok_halt[SRC_EXT0] = ~cfg.ext0_filter_on;
        ok_halt[SRC_EXT1] = ~cfg.ext1_filter_on;
        ok_halt[SRC_EXT3] = ~cfg.ext3_filter_on;
        ok_halt[SRC_VMON1] = 1'b1;
        ok_halt[SRC_VMON2] = 1'b1;
        ok_stop = '0;
        ok_stop[SRC_KEY] = 1'b1;
        ok_stop[SRC_PET] = pet_no_filt_evt & (cfg.pet_src == PET_SRC_EXT);
        ok_stop[SRC_SERIAL] = cfg.serial_ext_clk;
        ok_stop[SRC_EXT0] = ~cfg.ext0_filter_on;
        ok_stop[SRC_EXT1] = ~cfg.ext1_filter_on;
        ok_stop[SRC_EXT3] = ~cfg.ext3_filter_on;
        ok_stop[SRC_VMON1] = cfg.vmon1_filter_off;
        ok_stop[SRC_VMON2] = cfg.vmon2_filter_off;
    end

    assign live = irq_req & irq_enabled;
    assign sleep_wake = |(live & (periph_halt ? ok_halt : ok_run));
    assign stop_wake = |(live & ok_stop);
endmodule

/* File: logic/lpwc_core.sv */
// Low-power wake control: sleep/stop entry, wake qualification and wake sequencing
//
// What this block does
// - Sleep ends on reset or an enabled, qualified peripheral request.
// - Peripheral clocks running in sleep: every source except the A/D converter may always wake.
// - Peripheral clocks halted: only external- or oscillator-clocked peripherals wake.
// - Clocks running: A/D wakes only in single-conversion mode.
// - Clocks halted: pulse timer wakes if unfiltered event mode or oscillator source.
// - Clocks halted: calendar timer wakes only in real-time-clock mode.
// - Clocks halted: ext_irq0, ext_irq1, ext_irq3 wake only unfiltered.
// - Flash activation: 12 cycles, plus 30 us when flash stays powered.
// - Then 6 cycles CPU clock restart, then 20 cycles interrupt entry.
// - Wake from sleep keeps the CPU clock source and division.
// - Stop halts all oscillators; externally clocked peripherals keep running.
// - Stop: pulse timer wakes only unfiltered external event count; key always.
// - Stop: serial interrupt wakes only with external serial clock.
// - Stop: voltage monitors wake only with their digital filter off.
// - Sleep is entered when the CPU executes the sleep instruction.
// - Peripheral clock halt option gates f1..f32 during sleep.
// - Stop is entered when software sets all_clock_stop.
`timescale 1ns/1ps
module lpwc_core
    import lpwc_pkg::*;
#(
    parameter int FLASH_WAKE_CNT = FLASH_WAKE_CYCLES  // Shorten for simulation
)
(
    input wire logic ref_clk,                          // System clock, 125 MHz
    input wire logic sys_rst,                          // Synchronous reset, active high
    input wire logic sleep_instruction,                // CPU executes sleep, one-cycle pulse
    input wire logic all_clock_stop,                   // Software stop request, level
    input wire logic periph_clk_halt_in_sleep,         // Halt f1..f32 in sleep
    input wire logic flash_power_down,                 // Flash stays off in sleep
    input wire logic global_interrupt_mask,            // CPU interrupt enable flag
    input wire logic [NUM_SRC-1:0] irq_enabled,        // Priority level nonzero per source
    input wire logic [NUM_SRC-1:0] irq_req_pin,        // Raw requests, other domains
    input wire lpwc_periph_cfg_t periph_cfg,           // Peripheral wake setup
    input wire logic [3:0] cpu_clk_sel,                // Live CPU clock source/division
    input wire logic stop_div8_sel,                    // Divide-by-8 selection after stop
    output lpwc_clk_ctl_t clk_ctl,                     // Clock gating
    output logic [3:0] cpu_clk_sel_out,                // Clock setting in force
    output logic stop_div8,                            // Force divide-by-8 after stop
    output logic irq_entry,                            // Interrupt handler may start, pulse
    output logic low_power                             // In sleep or stop or waking
);
    localparam int FLASH_SHORT = FLASH_SYS_CYCLES;
    localparam int FLASH_LONG = FLASH_SYS_CYCLES + FLASH_WAKE_CNT;

    lpwc_state_t state_q;
    lpwc_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [NUM_SRC-1:0] req_s1_q;
    logic [NUM_SRC-1:0] req_s2_q;
    logic [3:0] clk_hold_q;
    logic from_stop_q;
    logic from_stop_d;
    logic halt_q;
    logic halt_d;
    lpwc_clk_ctl_t clk_ctl_q;
    lpwc_clk_ctl_t clk_ctl_d;
    logic [3:0] clk_sel_q;
    logic div8_q;
    logic entry_q;
    logic lp_q;
    logic sleep_wake;
    logic stop_wake;

    // Requests come from other clock domains
    always_ff @(posedge ref_clk) begin
        req_s1_q <= irq_req_pin;
        req_s2_q <= req_s1_q;
    end

    lpwc_wake_filter u_filter (
        .irq_req(req_s2_q),
        .irq_enabled(irq_enabled),
        .cfg(periph_cfg),
        .periph_halt(halt_q),
        .sleep_wake(sleep_wake),
        .stop_wake(stop_wake)
    );

    function automatic logic [CNT_W-1:0] to_cnt(input int n);
        to_cnt = CNT_W'(n - 1);
    endfunction

    // Global flag gates the wake itself, not only the handler; no wake without it
    wire wake_ok = global_interrupt_mask;
    wire cnt_done = (cnt_q == '0);
    wire [CNT_W-1:0] flash_cnt = flash_power_down ? to_cnt(FLASH_SHORT)
                                                  : to_cnt(FLASH_LONG);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
        from_stop_d = from_stop_q;
        halt_d = halt_q;
        case (state_q)
            PS_RUN: begin
                if (all_clock_stop) begin
                    state_d = PS_STOP;
                    from_stop_d = 1'b1;
                end else if (sleep_instruction) begin
                    state_d = PS_SLEEP;
                    from_stop_d = 1'b0;
                    halt_d = periph_clk_halt_in_sleep;
                end
            end
            PS_SLEEP: begin
                if (sleep_wake && wake_ok) begin
                    state_d = PS_FLASH;
                    cnt_d = flash_cnt;
                end
            end
            PS_STOP: begin
                if (stop_wake && wake_ok) begin
                    state_d = PS_FLASH;
                    cnt_d = flash_cnt;
                end
            end
            PS_FLASH: begin
                if (cnt_done) begin
                    state_d = PS_CLKRS;
                    cnt_d = to_cnt(CPU_RESTART_CYCLES);
                end
            end
            PS_CLKRS: begin
                if (cnt_done) begin
                    state_d = PS_IRQSQ;
                    cnt_d = to_cnt(IRQ_SEQ_CYCLES);
                end
            end
            PS_IRQSQ: begin
                if (cnt_done) begin
                    state_d = PS_RUN;
                end
            end
            default: begin
                state_d = PS_RUN;
            end
        endcase
    end

    // Gating follows the next state so outputs change with the state
    always_comb begin
        clk_ctl_d.cpu_clk_en = (state_d == PS_RUN) || (state_d == PS_CLKRS && cnt_d == '0)
                               || (state_d == PS_IRQSQ);
        clk_ctl_d.osc_en = (state_d != PS_STOP);
        clk_ctl_d.periph_clk_en = !((state_d == PS_STOP)
                                  || (state_d == PS_SLEEP && halt_d));
        clk_ctl_d.flash_en = !((state_d == PS_STOP || state_d == PS_SLEEP)
                               && flash_power_down);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= PS_RUN;
            cnt_q <= '0;
            from_stop_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            from_stop_q <= from_stop_d;
            halt_q <= halt_d;
        end
    end

    wire sleep_entry = (state_q == PS_RUN) && (state_d == PS_SLEEP);
    // Entry edge forwards the live setting; the held copy only lands one edge later
    wire [3:0] held_sel = sleep_entry ? cpu_clk_sel : clk_hold_q;

    // Clock setting captured at sleep entry so a stray write cannot change resume clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clk_hold_q <= 4'h0;
        end else if (sleep_entry) begin
            clk_hold_q <= cpu_clk_sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clk_ctl_q <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1,
                           flash_en: 1'b1};
            clk_sel_q <= 4'h0;
            div8_q <= 1'b0;
            entry_q <= 1'b0;
            lp_q <= 1'b0;
        end else begin
            clk_ctl_q <= clk_ctl_d;
            clk_sel_q <= (state_d != PS_RUN && !from_stop_d) ? held_sel : cpu_clk_sel;
            div8_q <= from_stop_d && (state_d != PS_RUN || state_q != PS_RUN) && stop_div8_sel;
            entry_q <= (state_q == PS_IRQSQ) && cnt_done;
            lp_q <= (state_d != PS_RUN);
        end
    end

    assign clk_ctl = clk_ctl_q;
    assign cpu_clk_sel_out = clk_sel_q;
    assign stop_div8 = div8_q;
    assign irq_entry = entry_q;
    assign low_power = lp_q;
endmodule

/* File: testbench/lpwc_core_properties.sv */
// Checker: port-level entry, gating and wake timing properties of the wake control
`timescale 1ns/1ps
module lpwc_core_properties
    import lpwc_pkg::*;
#(
    parameter int FLASH_WAKE_CNT = FLASH_WAKE_CYCLES  // Same shortening as the core
)
(
    input wire logic ref_clk,                   // System clock
    input wire logic sys_rst,                   // Synchronous reset
    input wire logic sleep_instruction,         // Sleep pulse
    input wire logic all_clock_stop,            // Stop request
    input wire logic periph_clk_halt_in_sleep,  // Halt option
    input wire lpwc_clk_ctl_t clk_ctl,          // Clock gating
    input wire logic [3:0] cpu_clk_sel_out,     // Clock setting in force
    input wire logic irq_entry,                 // Handler start pulse
    input wire logic low_power                  // Not in run
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire run_entry = !low_power && sleep_instruction && !all_clock_stop;

    a_sleep_entry: assert property (
        run_entry |=> low_power && !clk_ctl.cpu_clk_en)
        else $error("sleep entry did not stop the cpu clock");
    a_halt_gate: assert property (
        run_entry |=> clk_ctl.periph_clk_en == !$past(periph_clk_halt_in_sleep))
        else $error("peripheral clock gate wrong in sleep");
    a_stop_entry: assert property (
        !low_power && all_clock_stop |=>
        low_power && !clk_ctl.osc_en && !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en)
        else $error("stop entry left a clock running");
    a_flash_floor: assert property (
        $rose(low_power) |-> !clk_ctl.cpu_clk_en [*8])
        else $error("cpu clock back before flash activation");
    a_restart_seq: assert property (
        $rose(clk_ctl.cpu_clk_en) && low_power |-> !irq_entry [*8] ##[13:15] irq_entry)
        else $error("interrupt sequence length wrong");
    a_entry_pulse: assert property (
        irq_entry |-> !low_power ##1 !irq_entry)
        else $error("handler entry not a single pulse");
    a_exit_entry: assert property (
        $fell(low_power) |-> irq_entry)
        else $error("left low power without handler entry");
    a_clk_hold: assert property (
        low_power && $past(low_power) && clk_ctl.osc_en |-> $stable(cpu_clk_sel_out))
        else $error("cpu clock setting changed in sleep");
    a_reset_exit: assert property (
        $fell(sys_rst) |-> !low_power && clk_ctl == 4'hF && !irq_entry)
        else $error("reset did not leave low power");

    cover property (run_entry);
    cover property ($rose(low_power) && !clk_ctl.osc_en);
    cover property (irq_entry);
endmodule

bind lpwc_core lpwc_core_properties #(.FLASH_WAKE_CNT(FLASH_WAKE_CNT)) u_lpwc_core_properties (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sleep_instruction(sleep_instruction),
    .all_clock_stop(all_clock_stop), .periph_clk_halt_in_sleep(periph_clk_halt_in_sleep),
    .clk_ctl(clk_ctl), .cpu_clk_sel_out(cpu_clk_sel_out), .irq_entry(irq_entry),
    .low_power(low_power));

/* File: testbench/lpwc_partner.sv */
// Partner model: peripheral request flags, raised by an event and cleared on handler entry
`timescale 1ns/1ps
module lpwc_partner
    import lpwc_pkg::*;
(
    input wire logic ref_clk,                    // System clock
    input wire logic sys_rst,                    // Synchronous reset
    input wire logic fire,                       // Peripheral event, one cycle
    input wire logic [3:0] src,                  // Which peripheral fires
    input wire logic irq_entry,                  // CPU enters the handler
    output logic [NUM_SRC-1:0] irq_req_pin = '0  // Level request flags
);
    // Flag holds until serviced, so a slow wake still sees it
    always @(posedge ref_clk) begin
        if (sys_rst || irq_entry) begin
            irq_req_pin <= '0;
        end else if (fire) begin
            irq_req_pin[src] <= 1'b1;
        end
    end
endmodule

/* File: testbench/lpwc_core_tb_top.sv */
// Testbench: wake qualification table, wake latency, clock hold and reset exit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        miscompares++; \
        $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module lpwc_core_tb_top;
    import lpwc_pkg::*;
    localparam int FWC = 5;
    localparam int WAIT_MAX = 80;
    typedef struct packed {
        logic stop;
        logic halt;
        logic [3:0] src;
        lpwc_periph_cfg_t cfg;
        logic exp;
    } lpwc_row_t;
    // Filters on, timer on divided clock, unless a row lifts them
    localparam lpwc_row_t ROWS [27] = '{
        '{1'h0,1'h1,4'h2,12'h11C,1'h1},
        '{1'h0,1'h0,4'h3,12'h51C,1'h1}, '{1'h0,1'h0,4'h3,12'h11C,1'h0},
        '{1'h0,1'h0,4'h5,12'h11C,1'h1}, '{1'h0,1'h1,4'h5,12'h11C,1'h0},
        '{1'h0,1'h1,4'h1,12'h11C,1'h0}, '{1'h0,1'h1,4'hC,12'h11C,1'h0},
        '{1'h0,1'h1,4'h3,12'h51C,1'h0}, '{1'h0,1'h1,4'h0,12'h91C,1'h1},
        '{1'h0,1'h1,4'h0,12'h11C,1'h0}, '{1'h0,1'h1,4'h4,12'h15C,1'h1},
        '{1'h0,1'h1,4'h4,12'h11C,1'h0}, '{1'h0,1'h1,4'h4,12'h21C,1'h1},
        '{1'h0,1'h1,4'h6,12'h13C,1'h1}, '{1'h0,1'h1,4'h6,12'h11C,1'h0},
        '{1'h0,1'h1,4'h7,12'h11C,1'h0}, '{1'h0,1'h1,4'h9,12'h118,1'h1},
        '{1'h1,1'h0,4'h2,12'h11C,1'h1}, '{1'h1,1'h0,4'h4,12'h2DC,1'h1},
        '{1'h1,1'h0,4'h4,12'h15C,1'h0}, '{1'h1,1'h0,4'h0,12'h91C,1'h1},
        '{1'h1,1'h0,4'h0,12'h11C,1'h0}, '{1'h1,1'h0,4'hA,12'h11E,1'h1},
        '{1'h1,1'h0,4'hA,12'h11C,1'h0}, '{1'h1,1'h0,4'hB,12'h11D,1'h1},
        '{1'h1,1'h0,4'h8,12'h11C,1'h0}, '{1'h1,1'h0,4'h5,12'h11C,1'h0}};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sleep_instruction = 1'b0;
    logic all_clock_stop = 1'b0;
    logic halt = 1'b0;
    logic flash_power_down = 1'b1;
    logic gmask = 1'b1;
    logic [NUM_SRC-1:0] irq_enabled = '0;
    logic [NUM_SRC-1:0] irq_req_pin;
    lpwc_periph_cfg_t periph_cfg = '0;
    logic [3:0] cpu_clk_sel = 4'h0;
    logic fire = 1'b0;
    logic div8_sel = 1'b0;
    logic stop_div8;
    logic [3:0] src = 4'h0;
    lpwc_clk_ctl_t clk_ctl;
    logic [3:0] cpu_clk_sel_out;
    logic irq_entry;
    logic low_power;
    int miscompares = 0;
    int cmp_count = 0;
    int lat [2];

    lpwc_core #(.FLASH_WAKE_CNT(FWC)) u_lpwc_core (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sleep_instruction(sleep_instruction),
        .all_clock_stop(all_clock_stop), .periph_clk_halt_in_sleep(halt),
        .flash_power_down(flash_power_down), .global_interrupt_mask(gmask),
        .irq_enabled(irq_enabled), .irq_req_pin(irq_req_pin), .periph_cfg(periph_cfg),
        .cpu_clk_sel(cpu_clk_sel), .stop_div8_sel(div8_sel), .clk_ctl(clk_ctl),
        .cpu_clk_sel_out(cpu_clk_sel_out), .stop_div8(stop_div8), .irq_entry(irq_entry),
        .low_power(low_power));
    lpwc_partner u_lpwc_partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .fire(fire),
        .src(src), .irq_entry(irq_entry), .irq_req_pin(irq_req_pin));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        tick(3);
        sys_rst <= 1'b0;
        tick(1);
    endtask
    task automatic enter(input logic stop);
        if (stop) begin
            all_clock_stop <= 1'b1;
        end else begin
            sleep_instruction <= 1'b1;
        end
        tick(1);
        all_clock_stop <= 1'b0;
        sleep_instruction <= 1'b0;
        tick(3);
    endtask
    task automatic wake_wait(output int c);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        c = 1;
        while (irq_entry !== 1'b1 && c < WAIT_MAX) begin
            tick(1);
            c++;
        end
    endtask
    task automatic run_row(input lpwc_row_t r, input int idx);
        int c;
        do_reset();
        halt <= r.halt;
        periph_cfg <= r.cfg;
        src <= r.src;
        irq_enabled <= 13'h0001 << r.src;
        enter(r.stop);
        wake_wait(c);
        `CHK("woke", r.exp, logic'(c < WAIT_MAX))
        $display("row %0d done", idx);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        lpwc_row_t r;
        int c;
        do_reset();
        `CHK("clk_ctl", 4'hF, clk_ctl)
        `CHK("low_power", 1'b0, low_power)
        foreach (ROWS[i]) begin
            run_row(ROWS[i], i);
        end
        // Interrupts masked: a usable source must not end sleep
        r = ROWS[0];
        r.exp = 1'b0;
        gmask <= 1'b0;
        run_row(r, 100);
        gmask <= 1'b1;
        halt <= 1'b0;
        for (int f = 0; f < 2; f++) begin
            do_reset();
            flash_power_down <= f[0];
            enter(1'b0);
            wake_wait(lat[f]);
        end
        `CHK("flash_extra", FWC, lat[0] - lat[1])
        `CHK("wake_latency", 1'b1, logic'(lat[1] >= 38 && lat[1] <= 44))
        $display("latency test done");
        do_reset();
        cpu_clk_sel <= 4'hA;
        tick(1);
        enter(1'b0);
        cpu_clk_sel <= 4'h3;
        tick(2);
        `CHK("clk_sel_held", 4'hA, cpu_clk_sel_out)
        `CHK("sleep_gates", 4'h6, clk_ctl)
        wake_wait(c);
        tick(2);
        `CHK("clk_sel_live", 4'h3, cpu_clk_sel_out)
        $display("clock hold test done");
        div8_sel <= 1'b1;
        enter(1'b1);
        `CHK("in_stop", 1'b1, low_power)
        `CHK("stop_gates", 4'h0, clk_ctl)
        `CHK("stop_div8", 1'b1, stop_div8)
        do_reset();
        `CHK("stop_left", 1'b0, low_power)
        `CHK("div8_cleared", 1'b0, stop_div8)
        `CHK("clk_restored", 4'hF, clk_ctl)
        $display("reset exit test done");
        conclude();
    end

    // Tests need about 2150 cycles; this allows more than five times that
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule
